// file: hdl/imc_params.svh
`ifndef IMC_PARAMS_SVH
`define IMC_PARAMS_SVH

// Register offsets
`define IMC_ADDR_PIN_ROUTE   8'ha6
`define IMC_ADDR_INT_ENABLE  8'ha9
`define IMC_ADDR_CONTROL     8'he1
`define IMC_ADDR_DATA        8'he2

// Reset values
`define IMC_RST_PIN_ROUTE    8'h00
`define IMC_RST_INT_ENABLE   8'h00
`define IMC_RST_CONTROL      8'h04
`define IMC_RST_DATA         8'h00

// Field positions
`define IMC_BIT_PIN_SELECT   4
`define IMC_BIT_IRQ_ENABLE   6
`define IMC_BIT_MASTER_EN    7
`define IMC_BIT_ACK_OUT      6
`define IMC_BIT_BYTE_DONE    5
`define IMC_BIT_ACK_IN       4
`define IMC_BIT_START        3
`define IMC_BIT_STOP         2

// Bit 4 of the interrupt enable register is reserved and reads zero
`define IMC_INT_ENABLE_MASK  8'hef

// Link clock cycles per quarter bit, minus one, for divide by 4/16/64/256
`define IMC_QTR_MAX_DIV4     6'h00
`define IMC_QTR_MAX_DIV16    6'h03
`define IMC_QTR_MAX_DIV64    6'h0f
`define IMC_QTR_MAX_DIV256   6'h3f

// Index of the acknowledge bit within a byte slot
`define IMC_ACK_SLOT         4'h8

`endif

// file: hdl/imc_pkg.sv
package imc_pkg;

	typedef enum logic [1:0] {
		CMD_START = 2'b00,
		CMD_TX    = 2'b01,
		CMD_RX    = 2'b10,
		CMD_STOP  = 2'b11
	} imc_cmd_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_START = 3'b001,
		ST_BIT   = 3'b010,
		ST_RESP  = 3'b011,
		ST_HOLD  = 3'b100,
		ST_STOP  = 3'b101
	} imc_state_t;

endpackage : imc_pkg

// file: hdl/imc_fifo2.sv
`timescale 1ns/100ps
module imc_fifo2 #(
	parameter int W = 10
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         inValid,
	input  wire logic [W-1:0] inData,
	output logic              inReady,
	output logic              outValid,
	input  wire logic         outReady,
	output logic      [W-1:0] outData
);

	if (W < 1) begin : g_check
		$error("imc_fifo2: width must be at least one");
	end

	logic [W-1:0] mem_r [2];
	logic         wrPtr_r;
	logic         rdPtr_r;
	logic [1:0]   count_r;
	logic         push;
	logic         pop;

	assign inReady  = (count_r != 2'h2);
	assign outValid = (count_r != 2'h0);
	assign outData  = mem_r[rdPtr_r];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wrPtr_r] <= inData;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wrPtr_r <= 1'b0;
			rdPtr_r <= 1'b0;
			count_r <= 2'h0;
		end else begin
			if (push) wrPtr_r <= ~wrPtr_r;
			if (pop) rdPtr_r <= ~rdPtr_r;
			if (push && !pop) count_r <= count_r + 2'h1;
			else if (pop && !push) count_r <= count_r - 2'h1;
		end
	end

endmodule : imc_fifo2

// file: hdl/imc_xfer_sync.sv
`timescale 1ns/100ps
module imc_xfer_sync #(
	parameter int W = 13
) (
	input  wire logic         srcClk,
	input  wire logic         srcRst,
	input  wire logic         srcValid,
	input  wire logic [W-1:0] srcData,
	output logic              srcReady,
	input  wire logic         dstClk,
	input  wire logic         dstRst,
	output logic              dstValid,
	input  wire logic         dstReady,
	output logic      [W-1:0] dstData
);

	if (W < 1) begin : g_check
		$error("imc_xfer_sync: width must be at least one");
	end

	logic [W-1:0] hold_r;
	logic         reqTog_r;
	logic         ackMeta_r;
	logic         ackSync_r;
	logic         reqMeta_r;
	logic         reqSync_r;
	logic         ackTog_r;

	// Word is held stable from the request toggle until the acknowledge
	assign srcReady = (reqTog_r == ackSync_r);
	assign dstValid = (reqSync_r != ackTog_r);
	assign dstData  = hold_r;

	always_ff @(posedge srcClk) begin
		if (srcRst) begin
			hold_r   <= '0;
			reqTog_r <= 1'b0;
		end else if (srcValid && srcReady) begin
			hold_r   <= srcData;
			reqTog_r <= ~reqTog_r;
		end
	end

	always_ff @(posedge srcClk) begin
		if (srcRst) begin
			ackMeta_r <= 1'b0;
			ackSync_r <= 1'b0;
		end else begin
			ackMeta_r <= ackTog_r;
			ackSync_r <= ackMeta_r;
		end
	end

	always_ff @(posedge dstClk) begin
		if (dstRst) begin
			reqMeta_r <= 1'b0;
			reqSync_r <= 1'b0;
			ackTog_r  <= 1'b0;
		end else begin
			reqMeta_r <= reqTog_r;
			reqSync_r <= reqMeta_r;
			if (dstValid && dstReady) ackTog_r <= reqSync_r;
		end
	end

endmodule : imc_xfer_sync

// file: hdl/imc_master.sv
// Summary of operation
// - Bus clock and data go to port 0 bits 0/1 or port 3 bits 0/1.
// - Byte-done interrupt reaches the processor only when its enable is set.
// - When receiving, drive ACK after each byte, or NACK if selected.
// - Data register write during a transfer loads and sends the byte.
// - Data register read during a transfer returns it and receives next byte.
// - Clock pin is push-pull; data pin only pulls low over a pull-up.
// - Setting start sends START, then address and direction bits.
// - Each finished byte sets the done flag; software clears it.
`timescale 1ns/100ps
`include "imc_params.svh"
module imc_master
	import imc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       linkClk,
	input  wire logic [7:0] sfrAddr,
	input  wire logic       sfrWrEn,
	input  wire logic       sfrRdEn,
	input  wire logic [7:0] sfrWrData,
	output logic      [7:0] sfrRdData,
	output logic            busIrq,
	output logic            p0Bit0Out,
	output logic            p0Bit0Oe,
	output logic            p0Bit1Out,
	output logic            p0Bit1Oe,
	input  wire logic       p0Bit1In,
	output logic            p3Bit0Out,
	output logic            p3Bit0Oe,
	output logic            p3Bit1Out,
	output logic            p3Bit1Oe,
	input  wire logic       p3Bit1In
);

	// System clock domain
	logic [7:0]  pinRoute_r;
	logic [7:0]  intEnReg_r;
	logic [7:0]  dataShift_r;
	logic [7:0]  sfrRdData_r;
	logic        masterEn_r;
	logic        ackOutSel_r;
	logic        byteDone_r;
	logic        ackIn_r;
	logic        startReq_r;
	logic        stopReq_r;
	logic [1:0]  clkDiv_r;
	logic        started_r;
	logic        byteReq_r;
	imc_cmd_t    byteKind_r;
	logic        wrPin;
	logic        wrInt;
	logic        wrCtl;
	logic        wrDat;
	logic        rdDat;
	logic        active;
	logic        ctlStart;
	logic        cmdValid;
	logic        cmdReady;
	imc_cmd_t    cmdKind;
	logic        cmdIssue;
	logic [12:0] cmdWord;
	logic        respXValid;
	logic        respXReady;
	logic [9:0]  respXData;
	logic        respValid;
	logic        respPop;
	logic [9:0]  respData;
	logic [7:0]  rdValue;

	assign wrPin  = sfrWrEn && (sfrAddr == `IMC_ADDR_PIN_ROUTE);
	assign wrInt  = sfrWrEn && (sfrAddr == `IMC_ADDR_INT_ENABLE);
	assign wrCtl  = sfrWrEn && (sfrAddr == `IMC_ADDR_CONTROL);
	assign wrDat  = sfrWrEn && (sfrAddr == `IMC_ADDR_DATA);
	assign rdDat  = sfrRdEn && (sfrAddr == `IMC_ADDR_DATA);
	assign active = started_r && startReq_r && masterEn_r;
	assign ctlStart = wrCtl && sfrWrData[`IMC_BIT_START] && !startReq_r
		&& !sfrWrData[`IMC_BIT_STOP] && sfrWrData[`IMC_BIT_MASTER_EN];
	// stop waits until start is low
	assign cmdValid = byteReq_r || (started_r && stopReq_r && !startReq_r);
	assign cmdKind  = byteReq_r ? byteKind_r : CMD_STOP;
	assign cmdIssue = cmdValid && cmdReady;
	assign cmdWord  = {cmdKind, ackOutSel_r, clkDiv_r, dataShift_r};
	// Drain stalls while software writes the data register
	assign respPop  = respValid && !wrDat;
	assign busIrq    = byteDone_r && intEnReg_r[`IMC_BIT_IRQ_ENABLE];
	assign sfrRdData = sfrRdData_r;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pinRoute_r <= `IMC_RST_PIN_ROUTE;
			intEnReg_r <= `IMC_RST_INT_ENABLE;
		end else begin
			if (wrPin) pinRoute_r <= sfrWrData;
			if (wrInt) intEnReg_r <= sfrWrData & `IMC_INT_ENABLE_MASK;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			{masterEn_r, ackOutSel_r, startReq_r, stopReq_r} <= 4'h1;
			clkDiv_r <= 2'h0;
		end else if (wrCtl) begin
			masterEn_r  <= sfrWrData[`IMC_BIT_MASTER_EN];
			ackOutSel_r <= sfrWrData[`IMC_BIT_ACK_OUT];
			startReq_r  <= sfrWrData[`IMC_BIT_START];
			stopReq_r   <= sfrWrData[`IMC_BIT_STOP];
			clkDiv_r    <= sfrWrData[1:0];
		end
	end

	// done flag, set wins over the clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			byteDone_r <= 1'b0;
			ackIn_r    <= 1'b0;
		end else begin
			if (respPop) begin
				byteDone_r <= 1'b1;
				ackIn_r    <= respData[9];
			end else if (wrCtl && !sfrWrData[`IMC_BIT_BYTE_DONE]) begin
				byteDone_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dataShift_r <= `IMC_RST_DATA;
		end else if (wrDat) begin
			dataShift_r <= sfrWrData;
		end else if (respPop && respData[8]) begin
			dataShift_r <= respData[7:0];
		end
	end

	// Start may come in the same write that sets the enable
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			started_r <= 1'b0;
		end else if (ctlStart) begin
			started_r <= 1'b1;
		end else if (!masterEn_r) begin
			started_r <= 1'b0;
		end else if (cmdIssue && cmdKind == CMD_STOP) begin
			started_r <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			byteReq_r  <= 1'b0;
			byteKind_r <= CMD_START;
		end else if (ctlStart) begin
			byteReq_r  <= 1'b1;
			byteKind_r <= CMD_START;
		end else if (!masterEn_r) begin
			byteReq_r  <= 1'b0;
			byteKind_r <= CMD_START;
		end else if (wrDat && active) begin
			byteReq_r  <= 1'b1;
			byteKind_r <= CMD_TX;
		end else if (rdDat && active) begin
			byteReq_r  <= 1'b1;
			byteKind_r <= CMD_RX;
		end else if (cmdIssue && byteReq_r) begin
			byteReq_r  <= 1'b0;
		end
	end

	always_comb begin
		rdValue = 8'h00;
		case (sfrAddr)
			`IMC_ADDR_PIN_ROUTE:  rdValue = pinRoute_r;
			`IMC_ADDR_INT_ENABLE: rdValue = intEnReg_r;
			`IMC_ADDR_CONTROL:    rdValue = {masterEn_r, ackOutSel_r,
				byteDone_r, ackIn_r, startReq_r, stopReq_r, clkDiv_r};
			`IMC_ADDR_DATA:       rdValue = dataShift_r;
			default:              rdValue = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) sfrRdData_r <= 8'h00;
		else sfrRdData_r <= sfrRdEn ? rdValue : 8'h00;
	end

	// Link clock domain
	logic        linkRstMeta_r;
	logic        linkRst;
	logic        enMeta_r;
	logic        enSync_r;
	logic        pselMeta_r;
	logic        pselSync_r;
	logic [1:0]  sdaMeta_r;
	logic [1:0]  sdaSync_r;
	imc_state_t  state_r;
	imc_cmd_t    kind_r;
	logic [1:0]  qtr_r;
	logic [5:0]  tickCnt_r;
	logic [5:0]  qtrMax;
	logic [3:0]  bitCnt_r;
	logic [7:0]  shift_r;
	logic [1:0]  div_r;
	logic        ackOut_r;
	logic        ackSeen_r;
	logic        sclLevel_r;
	logic        sdaLow_r;
	logic        cmdLValid;
	logic        cmdLReady;
	logic [12:0] cmdLData;
	logic        running;
	logic        tick;
	logic        sdaIn;
	logic        sclOe;
	logic        sdaOe;
	logic        respFValid;
	logic        respFReady;
	logic [9:0]  respFData;

	always_ff @(posedge linkClk) begin
		linkRstMeta_r <= sys_rst;
		linkRst       <= linkRstMeta_r;
	end

	always_ff @(posedge linkClk) begin
		enMeta_r   <= masterEn_r;
		enSync_r   <= enMeta_r;
		pselMeta_r <= pinRoute_r[`IMC_BIT_PIN_SELECT];
		pselSync_r <= pselMeta_r;
		sdaMeta_r  <= {p3Bit1In, p0Bit1In};
		sdaSync_r  <= sdaMeta_r;
	end

	assign cmdLReady = (state_r == ST_IDLE) || (state_r == ST_HOLD);
	assign running   = (state_r == ST_START) || (state_r == ST_BIT)
		|| (state_r == ST_STOP);
	assign tick      = running && (tickCnt_r == qtrMax);
	assign sdaIn     = pselSync_r ? sdaSync_r[1] : sdaSync_r[0];

	always_comb begin
		case (div_r)
			2'h0:    qtrMax = `IMC_QTR_MAX_DIV4;
			2'h1:    qtrMax = `IMC_QTR_MAX_DIV16;
			2'h2:    qtrMax = `IMC_QTR_MAX_DIV64;
			default: qtrMax = `IMC_QTR_MAX_DIV256;
		endcase
	end

	always_ff @(posedge linkClk) begin
		if (linkRst || !running || tick) tickCnt_r <= 6'h00;
		else tickCnt_r <= tickCnt_r + 6'h01;
	end

	always_ff @(posedge linkClk) begin
		if (linkRst) begin
			state_r    <= ST_IDLE;
			kind_r     <= CMD_START;
			qtr_r      <= 2'h0;
			bitCnt_r   <= 4'h0;
			shift_r    <= 8'h00;
			div_r      <= 2'h0;
			ackOut_r   <= 1'b0;
			ackSeen_r  <= 1'b0;
			sclLevel_r <= 1'b1;
			sdaLow_r   <= 1'b0;
		end else begin
			if (tick) qtr_r <= qtr_r + 2'h1;
			case (state_r)
				ST_IDLE, ST_HOLD: begin
					qtr_r <= 2'h0;
					if (cmdLValid) begin
						kind_r   <= imc_cmd_t'(cmdLData[12:11]);
						ackOut_r <= cmdLData[10];
						div_r    <= cmdLData[9:8];
						shift_r  <= cmdLData[7:0];
						bitCnt_r <= 4'h0;
						if (cmdLData[12:11] == CMD_START) state_r <= ST_START;
						else if (cmdLData[12:11] != CMD_STOP) state_r <= ST_BIT;
						else if (state_r == ST_HOLD) state_r <= ST_STOP;
					end
				end
				// start condition, then the address byte
				ST_START: if (tick) begin
					case (qtr_r)
						2'h0:    sdaLow_r <= 1'b0;
						2'h1:    sclLevel_r <= 1'b1;
						2'h2:    sdaLow_r <= 1'b1;
						default: begin
							sclLevel_r <= 1'b0;
							state_r    <= ST_BIT;
						end
					endcase
				end
				ST_BIT: if (tick) begin
					case (qtr_r)
						2'h0: begin
							if (bitCnt_r == `IMC_ACK_SLOT) begin
								sdaLow_r <= (kind_r == CMD_RX) && !ackOut_r;
							end else begin
								sdaLow_r <= (kind_r != CMD_RX) && !shift_r[7];
							end
						end
						2'h1:    sclLevel_r <= 1'b0;
						2'h2:    sclLevel_r <= 1'b1;
						default: begin
							sclLevel_r <= 1'b0;
							if (bitCnt_r == `IMC_ACK_SLOT) begin
								ackSeen_r <= sdaIn;
								state_r   <= ST_RESP;
							end else begin
								shift_r  <= {shift_r[6:0], sdaIn};
								bitCnt_r <= bitCnt_r + 4'h1;
							end
						end
					endcase
				end
				ST_RESP: if (respXReady) begin
					sdaLow_r <= 1'b0;
					state_r  <= ST_HOLD;
				end
				ST_STOP: if (tick) begin
					case (qtr_r)
						2'h0:    sdaLow_r <= 1'b1;
						2'h1:    sclLevel_r <= 1'b0;
						2'h2:    sclLevel_r <= 1'b1;
						default: begin
							sdaLow_r <= 1'b0;
							state_r  <= ST_IDLE;
						end
					endcase
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	assign respXValid = (state_r == ST_RESP);
	assign respXData  = {ackSeen_r, kind_r == CMD_RX, shift_r};

	// push-pull clock, data pulled low only
	assign sclOe = enSync_r;
	assign sdaOe = enSync_r && sdaLow_r;
	assign p0Bit0Out = sclLevel_r;
	assign p3Bit0Out = sclLevel_r;
	assign p0Bit1Out = 1'b0;
	assign p3Bit1Out = 1'b0;
	assign p0Bit0Oe  = sclOe && !pselSync_r;
	assign p0Bit1Oe  = sdaOe && !pselSync_r;
	assign p3Bit0Oe  = sclOe && pselSync_r;
	assign p3Bit1Oe  = sdaOe && pselSync_r;

	imc_xfer_sync #(.W(13)) u_cmd_sync (
		.srcClk(clk), .srcRst(sys_rst), .srcValid(cmdValid),
		.srcData(cmdWord), .srcReady(cmdReady), .dstClk(linkClk),
		.dstRst(linkRst), .dstValid(cmdLValid), .dstReady(cmdLReady),
		.dstData(cmdLData)
	);

	imc_xfer_sync #(.W(10)) u_resp_sync (
		.srcClk(linkClk), .srcRst(linkRst), .srcValid(respXValid),
		.srcData(respXData), .srcReady(respXReady), .dstClk(clk),
		.dstRst(sys_rst), .dstValid(respFValid), .dstReady(respFReady),
		.dstData(respFData)
	);

	imc_fifo2 #(.W(10)) u_resp_buf (
		.clk(clk), .rst(sys_rst), .inValid(respFValid), .inData(respFData),
		.inReady(respFReady), .outValid(respValid), .outReady(respPop),
		.outData(respData)
	);

	property p_pin_route;
		@(posedge linkClk) disable iff (linkRst)
		!pselSync_r |-> !p3Bit0Oe && !p3Bit1Oe && (p0Bit0Oe == enSync_r);
	endproperty
	a_pin_route: assert property (p_pin_route)
		else $error("bus pins driven on the unselected port");

	property p_irq_gate;
		@(posedge clk) disable iff (sys_rst)
		byteDone_r && !intEnReg_r[`IMC_BIT_IRQ_ENABLE] |-> !busIrq;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("interrupt raised while disabled");

	property p_ack_out;
		@(posedge linkClk) disable iff (linkRst)
		state_r == ST_BIT && bitCnt_r == `IMC_ACK_SLOT && qtr_r == 2'h2
		&& kind_r == CMD_RX |-> sdaLow_r == !ackOut_r;
	endproperty
	a_ack_out: assert property (p_ack_out)
		else $error("wrong acknowledge level on receive");

	property p_tx_load;
		@(posedge clk) disable iff (sys_rst)
		wrDat && active && !ctlStart |=> byteReq_r && byteKind_r == CMD_TX
		&& dataShift_r == $past(sfrWrData);
	endproperty
	a_tx_load: assert property (p_tx_load)
		else $error("data write did not queue a send");

	property p_rx_launch;
		@(posedge clk) disable iff (sys_rst)
		rdDat && active && !wrDat && !ctlStart |=> byteReq_r
		&& byteKind_r == CMD_RX;
	endproperty
	a_rx_launch: assert property (p_rx_launch)
		else $error("data read did not queue a receive");

	property p_pin_drive;
		@(posedge linkClk) disable iff (linkRst)
		enSync_r |-> (p0Bit0Oe || p3Bit0Oe) && !p0Bit1Out && !p3Bit1Out;
	endproperty
	a_pin_drive: assert property (p_pin_drive)
		else $error("clock pin not driven or data driven high");

	property p_divider;
		@(posedge linkClk) disable iff (linkRst)
		tick && div_r == 2'h3 && state_r == ST_BIT |=> !tick [*8];
	endproperty
	a_divider: assert property (p_divider)
		else $error("quarter bit shorter than divide by 256");

	property p_start_seq;
		@(posedge linkClk) disable iff (linkRst)
		state_r == ST_START ##1 state_r == ST_BIT |-> !sclLevel_r
		&& sdaLow_r && bitCnt_r == 4'h0;
	endproperty
	a_start_seq: assert property (p_start_seq)
		else $error("start condition not formed before address");

	property p_done_flag;
		@(posedge clk) disable iff (sys_rst)
		respPop |=> byteDone_r;
	endproperty
	a_done_flag: assert property (p_done_flag)
		else $error("finished byte did not set the done flag");

endmodule : imc_master

// file: verification/imc_slave_model.sv
`timescale 1ns/100ps
module imc_slave_model (
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       nackMode,
	input  wire logic [7:0] txBase,
	output logic            sdaLow,
	output logic            busy,
	output logic      [7:0] rxByte,
	output logic            masterAck
);
	logic [7:0] sh;
	logic [7:0] txCnt;
	logic [7:0] cur;
	int         bitCnt;
	logic       first;
	logic       reading;

	initial begin
		sdaLow = 1'b0;
		busy = 1'b0;
		rxByte = 8'h00;
		masterAck = 1'b0;
		txCnt = 8'h00;
	end

	always @(negedge sda) if (scl === 1'b1) begin
		busy = 1'b1;
		// The falling clock that ends START is not a bit
		bitCnt = -1;
		first = 1'b1;
		reading = 1'b0;
		txCnt = 8'h00;
	end

	always @(posedge sda) if (scl === 1'b1) busy = 1'b0;

	always @(posedge scl) if (busy) begin
		if (bitCnt < 8)
			sh = {sh[6:0], sda};
		else if (reading)
			masterAck = sda;
	end

	always @(negedge scl) if (busy) begin
		bitCnt = bitCnt + 1;
		sdaLow = 1'b0;
		if (bitCnt == 8 && !reading) begin
			rxByte = sh;
			if (first)
				reading = sh[0];
			sdaLow = !nackMode;
		end
		if (bitCnt == 9) begin
			bitCnt = 0;
			if (reading && !first)
				txCnt = txCnt + 8'h01;
			if (reading && !first && masterAck)
				reading = 1'b0;
			first = 1'b0;
		end
		cur = txBase + txCnt;
		if (reading && bitCnt < 8)
			sdaLow = !cur[7 - bitCnt];
	end
endmodule : imc_slave_model

// file: verification/tb_top.sv
`timescale 1ns/100ps
`include "imc_params.svh"
module tb_top
	import imc_pkg::*;
;
	localparam logic [7:0] PIN = `IMC_ADDR_PIN_ROUTE;
	localparam logic [7:0] IEN = `IMC_ADDR_INT_ENABLE;
	localparam logic [7:0] CTL = `IMC_ADDR_CONTROL;
	localparam logic [7:0] DAT = `IMC_ADDR_DATA;

	logic       clk;
	logic       sys_rst;
	logic       linkClk;
	logic [7:0] sfrAddr;
	logic       sfrWrEn;
	logic       sfrRdEn;
	logic [7:0] sfrWrData;
	logic [7:0] sfrRdData;
	logic       busIrq;
	logic       p0Bit0Out, p0Bit0Oe, p0Bit1Out, p0Bit1Oe;
	logic       p3Bit0Out, p3Bit0Oe, p3Bit1Out, p3Bit1Oe;
	logic       sel, nack, slvLow, slvBusy, slvMAck;
	logic [7:0] slvRx;
	logic       sclW, sda0, sda3;
	realtime    tPrev, tLast;
	int         nTests = 0;
	int         nMismatch = 0;
	logic [7:0] adrTab [4] = '{PIN, IEN, CTL, DAT};
	logic [7:0] rstTab [4] = '{`IMC_RST_PIN_ROUTE, `IMC_RST_INT_ENABLE,
		`IMC_RST_CONTROL, `IMC_RST_DATA};

	// Pull-ups on the clock wire of the selected port and on the data wires of both ports
	assign sclW = sel ? (p3Bit0Oe ? p3Bit0Out : 1'b1)
		: (p0Bit0Oe ? p0Bit0Out : 1'b1);
	assign sda0 = !(p0Bit1Oe || (!sel && slvLow));
	assign sda3 = !(p3Bit1Oe || (sel && slvLow));

	imc_master uut (
		.clk(clk), .sys_rst(sys_rst), .linkClk(linkClk),
		.sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn),
		.sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .busIrq(busIrq),
		.p0Bit0Out(p0Bit0Out), .p0Bit0Oe(p0Bit0Oe),
		.p0Bit1Out(p0Bit1Out), .p0Bit1Oe(p0Bit1Oe), .p0Bit1In(sda0),
		.p3Bit0Out(p3Bit0Out), .p3Bit0Oe(p3Bit0Oe),
		.p3Bit1Out(p3Bit1Out), .p3Bit1Oe(p3Bit1Oe), .p3Bit1In(sda3)
	);

	imc_slave_model slave (
		.scl(sclW), .sda(sel ? sda3 : sda0), .nackMode(nack),
		.txBase(8'h3c), .sdaLow(slvLow), .busy(slvBusy),
		.rxByte(slvRx), .masterAck(slvMAck)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		linkClk = 1'b0;
		#7.3;
		forever #24 linkClk = ~linkClk;
	end

	initial begin
		tPrev = 0;
		tLast = 0;
	end

	always @(posedge sclW) begin
		tPrev = tLast;
		tLast = $realtime;
	end

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		nTests++;
		if (g !== e) begin
			nMismatch++;
			$display("BAD %s expected %h got %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) #1;
		sfrAddr = a;
		sfrWrData = d;
		sfrWrEn = 1'b1;
		@(posedge clk) #1;
		sfrWrEn = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk) #1;
		sfrAddr = a;
		sfrRdEn = 1'b1;
		@(posedge clk) #1;
		sfrRdEn = 1'b0;
		d = sfrRdData;
	endtask : rd

	task automatic waitDone(output logic [7:0] v);
		int k;
		k = 0;
		v = 8'h00;
		while (v[5] !== 1'b1 && k < 40000) begin
			rd(CTL, v);
			k++;
		end
		chk("done", 16'h0001, v[5]); // flag set
	endtask : waitDone

	task automatic startXfer(input logic [7:0] a, input logic [7:0] c,
		output logic [7:0] v);
		wr(DAT, a);
		wr(CTL, c);
		waitDone(v);
	endtask : startXfer

	task automatic finishXfer(input int code);
		int k;
		k = 0;
		wr(CTL, 8'h84 | 8'(code));
		while (slvBusy && k < 100000) begin
			@(posedge clk);
			k++;
		end
		chk("stop", 16'h0000, slvBusy); // stop seen
		// start idle over one bus clock
		repeat (80 << (2 * code)) @(posedge clk);
	endtask : finishXfer

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", nTests, nMismatch);
		if (nMismatch == 0 && nTests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop

	initial begin
		// About twice the expected run, slowest divider included
		#450000;
		nMismatch++;
		report_and_stop();
	end

	initial begin
		logic [7:0] v;
		int c;
		sfrAddr = 8'h00;
		sfrWrEn = 1'b0;
		sfrRdEn = 1'b0;
		sfrWrData = 8'h00;
		sys_rst = 1'b1;
		sel = 1'b0;
		nack = 1'b0;
		repeat (8) @(posedge clk);
		#1 sys_rst = 1'b0;
		repeat (50) @(posedge clk);
		for (c = 0; c < 4; c++) begin
			rd(adrTab[c], v);
			chk("resetVal", rstTab[c], v); // reset
		end
		wr(IEN, 8'hff);
		rd(IEN, v);
		chk("ienMask", `IMC_INT_ENABLE_MASK, v); // reserved bit
		wr(8'h00, 8'hff);
		rd(8'h00, v);
		chk("unmapped", 8'h00, v);
		wr(CTL, 8'h30);
		rd(CTL, v);
		chk("ctlRo", 8'h00, v); // set ignored
		wr(IEN, 8'h00);
		$display("test registers done");

		startXfer(8'h54, 8'h88, v);
		chk("irqOff", 16'h0000, busIrq); // masked
		wr(IEN, 8'h40);
		chk("irqOn", 16'h0001, busIrq); // enabled
		wr(CTL, 8'h88);
		chk("irqClr", 16'h0000, busIrq); // cleared
		wr(DAT, 8'ha5);
		waitDone(v);
		chk("txByte", 8'ha5, slvRx); // data sent
		finishXfer(0);
		$display("test transmit done");

		for (c = 0; c < 4; c++) begin
			startXfer(8'h54, 8'h88 | 8'(c), v);
			chk("addr", 8'h54, slvRx); // address
			chk("ackIn", 16'h0000, v[4]); // acked
			chk("bitTime", 16'(48 * (4 << (2 * c))),
				16'(int'(tLast - tPrev))); // divider
			chk("sclOe0", 16'h0001, p0Bit0Oe); // clock drive
			chk("sclOe3", 16'h0000, p3Bit0Oe); // other port
			chk("sdaOut", 16'h0000, p0Bit1Out); // low only
			finishXfer(c);
		end
		$display("test dividers done");

		wr(PIN, 8'h10);
		sel = 1'b1;
		nack = 1'b1;
		startXfer(8'h54, 8'h88, v);
		chk("ackInNack", 16'h0001, v[4]); // refused
		chk("sclOe3", 16'h0001, p3Bit0Oe); // port three
		chk("sclOe0", 16'h0000, p0Bit0Oe); // other port
		chk("sdaOut3", 16'h0000, p3Bit1Out); // low only
		finishXfer(0);
		nack = 1'b0;
		$display("test port select done");

		startXfer(8'h55, 8'h88, v);
		wr(CTL, 8'h88);
		rd(DAT, v); // value discarded
		waitDone(v);
		wr(CTL, 8'h88);
		rd(DAT, v);
		chk("rx0", 8'h3c, v); // first byte
		chk("ackOut", 16'h0000, slvMAck); // ack given
		waitDone(v);
		wr(CTL, 8'hcc); // nack and stop first
		rd(DAT, v);
		chk("rx1", 8'h3d, v); // second byte
		waitDone(v);
		chk("nackOut", 16'h0001, slvMAck); // nack given
		finishXfer(0);
		rd(DAT, v);
		chk("rx2", 8'h3e, v); // last byte
		$display("test receive done");
		report_and_stop();
	end
endmodule : tb_top
